/* File: hw/felsq_pkg.sv */
// Package of constants and types for the flash erase and lock sequencer.
//
// Functional notes
// RULE_01: A valid erase command written to the command register starts the erase at once.
// RULE_02: Erase-pages argument bits 1:0 select 4, 8, 16 or 32 pages.
// RULE_03: Software uses 4 pages only in small sectors, never 32 there.
// RULE_04: Ready flag rises when an erase completes.
// RULE_05: With ready interrupt enabled, interrupt fires when ready rises after a command.
// RULE_06: A bad key in a command write sets the command error flag; the code sets it only while ready is high and drops a bad key while busy.
// RULE_07: Erase touching any locked page is refused whole and sets lock error.
// RULE_08: Failed erase verify at end of erase sets the flash error flag.
// RULE_09: Each lock bit covers a region of pages and blocks erasing it.
// RULE_10: Set-lock sets the lock bit of the region holding the argument page.
// RULE_11: Ready flag rises when a set-lock completes.
// RULE_12: Get-lock reports current lock bits so software can confirm them.
// RULE_13: Software keeps lock arguments within the implemented lock bit range.
// RULE_14: Failed verify after a lock operation sets flash error; bad key sets command error (in the code only while ready is high).
// RULE_15: Clear-lock clears the region lock bit so the region is usable again.
// RULE_16: Ready flag rises when a clear-lock completes.
// RULE_17: Ready stays low from command acceptance to finish; no command taken meanwhile.
package felsq_pkg;

  // =====================================================================
  // Register byte addresses.
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_MODE    = 8'h08;
  localparam logic [7:0] ADDR_RESULT  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;

  // =====================================================================
  // Command register fields: key 31:24, argument 23:8, code 7:0.
  localparam int         KEY_LSB   = 24;
  localparam int         ARG_LSB   = 8;
  localparam logic [7:0] CMD_KEY   = 8'h5a;
  localparam logic [7:0] CMD_ERASE = 8'h07;
  localparam logic [7:0] CMD_SETLK = 8'h08;
  localparam logic [7:0] CMD_CLRLK = 8'h09;
  localparam logic [7:0] CMD_GETLK = 8'h0a;

  // Erase page counts selected by argument bits 1:0.
  localparam logic [7:0] ERASE_CNT_SEL0 = 8'h04;
  localparam logic [7:0] ERASE_CNT_SEL1 = 8'h08;
  localparam logic [7:0] ERASE_CNT_SEL2 = 8'h10;
  localparam logic [7:0] ERASE_CNT_SEL3 = 8'h20;

  // Status bits.
  localparam int ST_READY = 0;
  localparam int ST_CMDE  = 1;
  localparam int ST_LOCKE = 2;
  localparam int ST_FLE   = 3;

  // Mode register bit: ready interrupt enable.
  localparam int MODE_RDY_IE = 0;

  // Interrupt status bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_W    = 2;

  // =====================================================================
  // Timing: page erase 1 us, lock program 1 us, cycles at 40 MHz.
  localparam int CLK_MHZ        = 40;
  localparam int PAGE_ERASE_NS  = 1000;
  localparam int LOCK_PROG_NS   = 1000;
  localparam int PAGE_ERASE_CYC = (PAGE_ERASE_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_PROG_CYC  = (LOCK_PROG_NS * CLK_MHZ + 999) / 1000;

  // Sequencer states.
  typedef enum logic [3:0] {
    FELSQ_IDLE  = 4'b0001,
    FELSQ_CHECK = 4'b0010,
    FELSQ_WORK  = 4'b0100,
    FELSQ_DONE  = 4'b1000
  } felsq_state_e;

endpackage

/* File: hw/felsq_lock_bits.sv */
// Lock bit store with one bit per region and a registered read-out.
`timescale 1ns/1ps
module felsq_lock_bits #(
  parameter int REGIONS = 16
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               set_en,
  input  wire logic               clr_en,
  input  wire logic [3:0]         region,
  output logic      [REGIONS-1:0] lock_q
);

  // The region number port is four bits wide.
  if (REGIONS > 16 || REGIONS < 1) begin : g_bad_regions
    $error("felsq_lock_bits: region count out of range");
  end

  // Each region bit is set or cleared on its own; set wins a tie.
  genvar g;
  generate
    for (g = 0; g < REGIONS; g++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          lock_q[g] <= 1'b0;
        end else if (set_en && region == 4'(g)) begin
          lock_q[g] <= 1'b1;
        end else if (clr_en && region == 4'(g)) begin
          lock_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // felsq_lock_bits

/* File: hw/felsq_top.sv */
// Flash erase and lock command sequencer with an AHB-Lite register slave.
`timescale 1ns/1ps
module felsq_top #(
  parameter int PAGES         = 256,
  parameter int PAGES_PER_LCK = 16,
  parameter int REGIONS       = 16
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             flash_erase_en,
  output logic      [7:0]  flash_page,
  output logic             flash_prog_lock,
  input  wire logic        flash_verify_fail,
  output logic             irq
);

  // =====================================================================
  // Elaboration checks: the lock store decodes a four-bit region number, the
  // page port is eight bits wide and the wait counter must hold one period.
  if (REGIONS > 16) begin : g_bad_regions
    $error("felsq_top: more lock regions than the lock store can decode");
  end
  if (REGIONS * PAGES_PER_LCK != PAGES) begin : g_bad_split
    $error("felsq_top: lock regions do not tile the flash plane");
  end
  if (PAGES > 256) begin : g_bad_pages
    $error("felsq_top: page number wider than the page port");
  end
  if (felsq_pkg::PAGE_ERASE_CYC > 256 || felsq_pkg::LOCK_PROG_CYC > 256) begin : g_bad_wait
    $error("felsq_top: operation period overflows the wait counter");
  end

  // =====================================================================
  // Bus slave: address phase capture.
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  addr_q;

  // Address phase of a valid transfer is captured for the data phase.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      rd_pend <= hsel && htrans[1] && !hwrite;
      addr_q  <= haddr[7:0];
    end
  end

  // Slave always ready and always answers OKAY.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // =====================================================================
  // Registers.
  localparam int IRQ_W_L = felsq_pkg::IRQ_W;

  felsq_pkg::felsq_state_e state;
  logic               ready;
  logic               cmd_err;
  logic               lock_err;
  logic               flash_err;
  logic               rdy_ie;
  logic [IRQ_W_L-1:0] irq_st;
  logic [IRQ_W_L-1:0] irq_msk;
  logic [31:0]        result;
  logic [7:0]         cmd_q;
  logic [15:0]        arg_q;
  logic [7:0]         page_cnt;
  logic [7:0]         page_idx;
  logic [7:0]         wait_cnt;
  logic               verify_bad;
  logic [REGIONS-1:0] lock_q;
  logic               lk_set;
  logic               lk_clr;

  logic        cmd_wr;
  logic        key_ok;
  logic        code_ok;
  logic        accept;
  logic [31:0] next_rdata;
  logic [7:0]  next_count;
  logic [7:0]  first_page;
  logic [REGIONS-1:0] hit_mask;
  logic        done_ev;
  logic        err_ev;

  assign cmd_wr  = wr_pend && addr_q == felsq_pkg::ADDR_COMMAND;
  assign key_ok  = hwdata[31:felsq_pkg::KEY_LSB] == felsq_pkg::CMD_KEY;
  assign code_ok = hwdata[7:0] == felsq_pkg::CMD_ERASE || hwdata[7:0] == felsq_pkg::CMD_SETLK ||
                   hwdata[7:0] == felsq_pkg::CMD_CLRLK || hwdata[7:0] == felsq_pkg::CMD_GETLK;
  // New commands are only taken while ready is high.
  assign accept  = cmd_wr && ready && key_ok && code_ok; // RULE_17

  // Page count from argument bits 1:0, start aligned to that count.
  always_comb begin
    case (hwdata[felsq_pkg::ARG_LSB +: 2]) // RULE_02
      2'h0:    next_count = felsq_pkg::ERASE_CNT_SEL0;
      2'h1:    next_count = felsq_pkg::ERASE_CNT_SEL1;
      2'h2:    next_count = felsq_pkg::ERASE_CNT_SEL2;
      default: next_count = felsq_pkg::ERASE_CNT_SEL3;
    endcase
    first_page = hwdata[felsq_pkg::ARG_LSB +: 8] & ~(next_count - 8'h01);
  end

  // Regions touched by the pending erase range.
  // Half-open intervals, so a range ending on a region boundary misses the next region.
  genvar r;
  generate
    for (r = 0; r < REGIONS; r++) begin : g_hit
      localparam int LO = r * PAGES_PER_LCK;
      localparam int HI = LO + PAGES_PER_LCK;
      assign hit_mask[r] = (32'(arg_q[7:0]) < HI) && (32'(arg_q[7:0]) + 32'(page_cnt) > LO);
    end
  endgenerate

  // Sequencer state machine.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= felsq_pkg::FELSQ_IDLE;
      cmd_q      <= 8'h00;
      arg_q      <= 16'h0000;
      page_cnt   <= 8'h00;
      page_idx   <= 8'h00;
      wait_cnt   <= 8'h00;
      verify_bad <= 1'b0;
    end else begin
      case (state)
        felsq_pkg::FELSQ_IDLE: begin
          verify_bad <= 1'b0;
          if (accept) begin // RULE_01
            cmd_q    <= hwdata[7:0];
            arg_q    <= {hwdata[23:16], hwdata[7:0] == felsq_pkg::CMD_ERASE ? first_page : hwdata[15:8]};
            page_cnt <= next_count;
            page_idx <= 8'h00;
            state    <= felsq_pkg::FELSQ_CHECK;
          end
        end
        felsq_pkg::FELSQ_CHECK: begin
          // Erase and lock programming may take different periods.
          if (cmd_q == felsq_pkg::CMD_ERASE) begin
            wait_cnt <= 8'(felsq_pkg::PAGE_ERASE_CYC - 1);
          end else begin
            wait_cnt <= 8'(felsq_pkg::LOCK_PROG_CYC - 1);
          end
          if (cmd_q == felsq_pkg::CMD_ERASE && |(hit_mask & lock_q)) begin
            state <= felsq_pkg::FELSQ_DONE; // RULE_07
          end else if (cmd_q == felsq_pkg::CMD_GETLK) begin
            state <= felsq_pkg::FELSQ_DONE; // RULE_12
          end else begin
            state <= felsq_pkg::FELSQ_WORK;
          end
        end
        felsq_pkg::FELSQ_WORK: begin
          if (flash_verify_fail && wait_cnt == 8'h00) begin
            verify_bad <= 1'b1; // RULE_08 RULE_14
          end
          if (wait_cnt != 8'h00) begin
            wait_cnt <= wait_cnt - 8'd1;
          end else if (cmd_q == felsq_pkg::CMD_ERASE && page_idx != page_cnt - 8'd1) begin
            page_idx <= page_idx + 8'd1;
            wait_cnt <= 8'(felsq_pkg::PAGE_ERASE_CYC - 1);
          end else begin
            state <= felsq_pkg::FELSQ_DONE;
          end
        end
        felsq_pkg::FELSQ_DONE: begin
          state <= felsq_pkg::FELSQ_IDLE;
        end
        default: state <= felsq_pkg::FELSQ_IDLE;
      endcase
    end
  end

  // Flash plane strobes and page address.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flash_erase_en  <= 1'b0;
      flash_prog_lock <= 1'b0;
      flash_page      <= 8'h00;
    end else begin
      flash_erase_en  <= state == felsq_pkg::FELSQ_WORK && cmd_q == felsq_pkg::CMD_ERASE;
      flash_prog_lock <= state == felsq_pkg::FELSQ_WORK && cmd_q != felsq_pkg::CMD_ERASE;
      flash_page      <= arg_q[7:0] + page_idx;
    end
  end

  // Lock updates happen when the lock program period ends cleanly.
  assign lk_set = state == felsq_pkg::FELSQ_WORK && wait_cnt == 8'h00 && !flash_verify_fail &&
                  cmd_q == felsq_pkg::CMD_SETLK; // RULE_10
  assign lk_clr = state == felsq_pkg::FELSQ_WORK && wait_cnt == 8'h00 && !flash_verify_fail &&
                  cmd_q == felsq_pkg::CMD_CLRLK; // RULE_15

  // Lock store; the region index is the page number divided by region size.
  felsq_lock_bits #(
    .REGIONS (REGIONS)
  ) u_lock (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_en  (lk_set),
    .clr_en  (lk_clr),
    .region  (4'(32'(arg_q[7:0]) / PAGES_PER_LCK)), // RULE_09
    .lock_q  (lock_q)
  );

  // Ready flag: low from acceptance until the sequencer passes its done state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ready <= 1'b1;
    end else if (accept) begin
      ready <= 1'b0; // RULE_17
    end else if (state == felsq_pkg::FELSQ_DONE) begin
      ready <= 1'b1; // RULE_04 RULE_11 RULE_16
    end
  end

  // Command error: set by a bad key while ready, cleared by the next accepted command.
  // A bad key while busy is dropped with the write, so a running command keeps its flags.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_err <= 1'b0;
    end else if (err_ev) begin
      cmd_err <= 1'b1; // RULE_06 RULE_14
    end else if (accept) begin
      cmd_err <= 1'b0;
    end
  end

  // Lock and flash errors report the command that has just finished.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lock_err  <= 1'b0;
      flash_err <= 1'b0;
    end else if (accept) begin
      lock_err  <= 1'b0;
      flash_err <= 1'b0;
    end else if (state == felsq_pkg::FELSQ_DONE) begin
      lock_err  <= cmd_q == felsq_pkg::CMD_ERASE && |(hit_mask & lock_q); // RULE_07
      flash_err <= verify_bad; // RULE_08 RULE_14
    end
  end

  // Get-lock result keeps the lock bits as they stood when that command finished.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result <= 32'h0000_0000;
    end else if (state == felsq_pkg::FELSQ_DONE && cmd_q == felsq_pkg::CMD_GETLK) begin
      result <= 32'(lock_q); // RULE_12
    end
  end

  assign done_ev = state == felsq_pkg::FELSQ_DONE;
  assign err_ev  = cmd_wr && ready && !key_ok;

  // Mode register: only the ready interrupt enable is kept.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdy_ie <= 1'b0;
    end else if (wr_pend && addr_q == felsq_pkg::ADDR_MODE) begin
      rdy_ie <= hwdata[felsq_pkg::MODE_RDY_IE];
    end
  end

  // Interrupt mask, same layout as the interrupt status.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_msk <= '0;
    end else if (wr_pend && addr_q == felsq_pkg::ADDR_IRQ_MSK) begin
      irq_msk <= hwdata[IRQ_W_L-1:0];
    end
  end

  // Interrupt status: sticky, write one to clear; an event in the clearing cycle wins.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_st <= '0;
    end else begin
      irq_st[felsq_pkg::IRQ_DONE] <= (done_ev && rdy_ie) || (irq_st[felsq_pkg::IRQ_DONE] &&
        !(wr_pend && addr_q == felsq_pkg::ADDR_IRQ_ST && hwdata[felsq_pkg::IRQ_DONE])); // RULE_05
      irq_st[felsq_pkg::IRQ_ERR] <= err_ev || (irq_st[felsq_pkg::IRQ_ERR] &&
        !(wr_pend && addr_q == felsq_pkg::ADDR_IRQ_ST && hwdata[felsq_pkg::IRQ_ERR]));
    end
  end

  // Interrupt line is high while any unmasked status bit is set.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st & irq_msk); // RULE_05
    end
  end

  // Read mux, decoded from the address phase; unmapped reads return zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr[7:0] == felsq_pkg::ADDR_STATUS) begin
      next_rdata[felsq_pkg::ST_READY] = ready;
      next_rdata[felsq_pkg::ST_CMDE]  = cmd_err;
      next_rdata[felsq_pkg::ST_LOCKE] = lock_err;
      next_rdata[felsq_pkg::ST_FLE]   = flash_err;
    end else if (haddr[7:0] == felsq_pkg::ADDR_MODE) begin
      next_rdata[felsq_pkg::MODE_RDY_IE] = rdy_ie;
    end else if (haddr[7:0] == felsq_pkg::ADDR_RESULT) begin
      next_rdata = result;
    end else if (haddr[7:0] == felsq_pkg::ADDR_IRQ_ST) begin
      next_rdata[IRQ_W_L-1:0] = irq_st;
    end else if (haddr[7:0] == felsq_pkg::ADDR_IRQ_MSK) begin
      next_rdata[IRQ_W_L-1:0] = irq_msk;
    end
  end

  // Read data is registered at the address phase so it stands through the zero-wait
  // data phase, then returns to zero. A read overlapping the data phase of a write
  // to the same register returns the value from before that write.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_rdata;
    end else if (rd_pend) begin
      hrdata <= 32'h0000_0000;
    end
  end

endmodule // felsq_top

/* File: testbench/felsq_props.sv */
// Port-level checker for the flash erase and lock sequencer.
`timescale 1ns/1ps
module felsq_props #(
  parameter int PAGES = 256
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hresp,
  input wire logic        hreadyout,
  input wire logic        flash_erase_en,
  input wire logic [7:0]  flash_page,
  input wire logic        flash_prog_lock,
  input wire logic        irq
);
  // ==========================================================
  // Helper logic
  logic        mask_dph;
  logic [10:0] run;

  // Marks the data phase of a write to the interrupt mask.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) mask_dph <= 1'b0;
    else if (hready) mask_dph <= hsel && htrans[1] && hwrite && (haddr[7:0] == felsq_pkg::ADDR_IRQ_MSK);
  end

  // Counts an unbroken stretch of erase strobe.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !flash_erase_en) run <= 11'h000;
    else run <= run + 11'h001;
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("Bus answer is not a zero-wait okay.");
  chk_one_op: assert property (!(flash_erase_en && flash_prog_lock))
    else $error("Erase and lock programming overlap.");
  chk_page_range: assert property (flash_erase_en |-> int'(flash_page) < PAGES)
    else $error("Erase page beyond the array.");
  chk_page_step: assert property (flash_erase_en && $past(flash_erase_en) && (flash_page != $past(flash_page))
    |-> flash_page == $past(flash_page) + 8'h01)
    else $error("Erase skipped a page.");
  chk_lock_steady: assert property (flash_prog_lock && $past(flash_prog_lock) |-> $stable(flash_page))
    else $error("Lock page moved during programming.");
  chk_lock_ends: assert property ($rose(flash_prog_lock) |-> ##[1:60] !flash_prog_lock)
    else $error("Lock programming did not finish.");
  chk_erase_ends: assert property (run <= 11'h578)
    else $error("Erase strobe runs too long.");
  chk_mask_quiet: assert property (mask_dph && hwdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("Interrupt stays high with all sources masked.");

  cov_erase: cover property ($rose(flash_erase_en));
  cov_lock: cover property ($rose(flash_prog_lock));
  cov_irq: cover property ($rose(irq));
endmodule // felsq_props

bind felsq_top felsq_props #(.PAGES(PAGES)) props_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hresp(hresp), .hreadyout(hreadyout), .flash_erase_en(flash_erase_en),
  .flash_page(flash_page), .flash_prog_lock(flash_prog_lock), .irq(irq));

/* File: testbench/felsq_flash_model.sv */
// Behavioural flash plane that logs erased pages and answers verify checks.
`timescale 1ns/1ps
module felsq_flash_model (
  input  wire logic         sys_clk,
  input  wire logic         clr_log,
  input  wire logic         fail_req,
  input  wire logic         flash_erase_en,
  input  wire logic [7:0]   flash_page,
  input  wire logic         flash_prog_lock,
  output logic              flash_verify_fail,
  output logic      [255:0] erased
);
  logic toggle;

  // Marks each page that sees the erase strobe; a refused erase leaves no mark.
  always_ff @(posedge sys_clk) begin
    toggle <= clr_log ? 1'b0 : ~toggle;
    if (clr_log) erased <= '0;
    else if (flash_erase_en) erased[flash_page] <= 1'b1;
  end

  // Verify result follows the request during an operation and toggles outside one.
  assign flash_verify_fail = (flash_erase_en || flash_prog_lock) ? fail_req : toggle;
endmodule // felsq_flash_model

/* File: testbench/felsq_tb_top.sv */
// Self-checking testbench for the flash erase and lock sequencer.
`timescale 1ns/1ps
module felsq_tb_top;
  logic         sys_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic         erase_en;
  logic [7:0]   page;
  logic         prog_lock;
  logic         verify_fail;
  logic         irq;
  logic         clr_log = 1'b1;
  logic         fail_req = 1'b0;
  logic [255:0] erased;
  int           n_errors = 0;
  int           tests_run = 0;

  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  felsq_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_erase_en(erase_en), .flash_page(page),
    .flash_prog_lock(prog_lock), .flash_verify_fail(verify_fail), .irq(irq));

  felsq_flash_model flash_u (.sys_clk(sys_clk), .clr_log(clr_log), .fail_req(fail_req),
    .flash_erase_en(erase_en), .flash_page(page), .flash_prog_lock(prog_lock),
    .flash_verify_fail(verify_fail), .erased(erased));

  // ==========================================================
  // Bus and comparison tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // One single AHB-Lite transfer; read data is taken at the end of the data phase.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(n, e, x);
  endtask

  // Issues a keyed command, then polls the ready flag under a bound.
  task automatic cmd(input logic [7:0] c, input logic [15:0] arg);
    logic [31:0] x;
    x = 32'h0;
    wr(felsq_pkg::ADDR_COMMAND, {felsq_pkg::CMD_KEY, arg, c});
    for (int i = 0; i < 2000 && x[0] !== 1'b1; i++)
      xfer(1'b0, felsq_pkg::ADDR_STATUS, 32'h0, x);
    chk("ready", 32'h1, {31'h0, x[0]});
  endtask

  task automatic clear_log;
    clr_log <= 1'b1;
    @(posedge sys_clk);
    clr_log <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd("status", felsq_pkg::ADDR_STATUS, 32'h1);
    wr(8'h18, 32'hffffffff);
    rd("mode", felsq_pkg::ADDR_MODE, 32'h0);
    rd("locks", felsq_pkg::ADDR_RESULT, 32'h0);
  endtask

  // Each page count from one aligned start in a large sector, with a refused mid-run command.
  task automatic t_erase;
    wr(felsq_pkg::ADDR_MODE, 32'h1);
    rd("mode on", felsq_pkg::ADDR_MODE, 32'h1);
    wr(felsq_pkg::ADDR_IRQ_MSK, 32'h1);
    for (int k = 0; k < 4; k++) begin
      clear_log;
      wr(felsq_pkg::ADDR_COMMAND, {felsq_pkg::CMD_KEY, 8'h0, 8'h40 | 8'(k), felsq_pkg::CMD_ERASE});
      rd("busy", felsq_pkg::ADDR_STATUS, 32'h0);
      cmd(felsq_pkg::CMD_ERASE, 16'h0000);
      chk("ignored", 32'h0, {31'h0, erased[0]});
      chk("pages", 32'h4 << k, 32'($countones(erased)));
      chk("start", 32'h1, {31'h0, erased[64]});
      chk("irq", 32'h1, {31'h0, irq});
      wr(felsq_pkg::ADDR_IRQ_ST, 32'h1);
      rd("irq st", felsq_pkg::ADDR_IRQ_ST, 32'h0);
      chk("irq off", 32'h0, {31'h0, irq});
    end
  endtask

  task automatic t_lock;
    wr(felsq_pkg::ADDR_IRQ_MSK, 32'h0);
    cmd(felsq_pkg::CMD_SETLK, 16'h0025);
    chk("masked", 32'h0, {31'h0, irq});
    cmd(felsq_pkg::CMD_GETLK, 16'h0000);
    rd("locks", felsq_pkg::ADDR_RESULT, 32'h4);
    clear_log;
    cmd(felsq_pkg::CMD_ERASE, 16'h0022);
    rd("lock err", felsq_pkg::ADDR_STATUS, 32'h5);
    chk("refused", 32'h0, 32'($countones(erased)));
    cmd(felsq_pkg::CMD_CLRLK, 16'h002f);
    rd("unlocked", felsq_pkg::ADDR_STATUS, 32'h1);
    cmd(felsq_pkg::CMD_GETLK, 16'h0000);
    rd("locks", felsq_pkg::ADDR_RESULT, 32'h0);
    cmd(felsq_pkg::CMD_ERASE, 16'h0022);
    chk("erased", 32'h10, 32'($countones(erased)));
  endtask

  task automatic t_errors;
    wr(felsq_pkg::ADDR_IRQ_ST, 32'h3);
    wr(felsq_pkg::ADDR_MODE, 32'h0);
    wr(felsq_pkg::ADDR_IRQ_MSK, 32'h2);
    wr(felsq_pkg::ADDR_COMMAND, 32'h11000107);
    rd("cmd err", felsq_pkg::ADDR_STATUS, 32'h3);
    rd("err st", felsq_pkg::ADDR_IRQ_ST, 32'h2);
    chk("err irq", 32'h1, {31'h0, irq});
    wr(felsq_pkg::ADDR_IRQ_MSK, 32'h0);
    rd("err kept", felsq_pkg::ADDR_IRQ_ST, 32'h2);
    chk("err masked", 32'h0, {31'h0, irq});
    wr(felsq_pkg::ADDR_IRQ_ST, 32'h2);
    rd("err clr", felsq_pkg::ADDR_IRQ_ST, 32'h0);
    fail_req <= 1'b1;
    cmd(felsq_pkg::CMD_ERASE, 16'h0080);
    rd("erase fl", felsq_pkg::ADDR_STATUS, 32'h9);
    cmd(felsq_pkg::CMD_SETLK, 16'h0090);
    rd("lock fl", felsq_pkg::ADDR_STATUS, 32'h9);
    rd("no done", felsq_pkg::ADDR_IRQ_ST, 32'h0);
    cmd(felsq_pkg::CMD_GETLK, 16'h0000);
    rd("no lock", felsq_pkg::ADDR_RESULT, 32'h0);
    fail_req <= 1'b0;
  endtask

  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    clr_log <= 1'b0;
    t_reset;
    t_erase;
    t_lock;
    t_errors;
    print_verdict;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    print_verdict;
  end
endmodule // felsq_tb_top
